// >>> dv/core_model.sv
`timescale 1ns/1ns
module core_model
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // controller side
  input irq_ctrl_pkg::vector_t vectorOut,
  output logic return_from_interrupt_op,
  // bench side
  input wire logic retReq
);
  logic [15:0] pc_q;
  logic [4:0] depth_q;
  logic [15:0] stack_q [32];
  // ************************************
  // entry pushes, return pops
  // ************************************
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      depth_q <= 5'h00;
      pc_q <= 16'h0000;
    end
    else if (vectorOut.take)
    begin
      stack_q[depth_q] <= pc_q + 16'h0002;
      depth_q <= depth_q + 5'h01;
      pc_q <= vectorOut.addr;
    end
    else if (retReq && depth_q != 5'h00)
    begin
      pc_q <= stack_q[depth_q - 5'h01];
      depth_q <= depth_q - 5'h01;
    end
  end
  // a return is only issued while a routine is open
  always_ff @(posedge ref_clk)
    return_from_interrupt_op <= reset_n && retReq && depth_q != 5'h00 && !vectorOut.take;
endmodule

// >>> dv/two_level_priority_interrupt_unit_tb_top.sv
`timescale 1ns/1ns
`include "irq_ctrl_map.svh"
module two_level_priority_interrupt_unit_tb_top;
  import irq_ctrl_pkg::*;
  logic ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, retOp, retReq;
  logic [7:0] awaddr, araddr, periphEvents;
  logic [31:0] wdata, rdata, rng;
  logic [3:0] wstrb, portPins;
  logic [1:0] bresp, rresp;
  logic [2:0] extPins;
  vector_t vectorOut;
  int err_total, comparisons, cyc, lat, k, j;
  logic [33:0] rdQ[$];
  logic [16:0] vecQ[$];
  two_level_priority_interrupt_unit #(.NUM_PERIPH(8)) u_two_level_priority_interrupt_unit (
    .ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .extPins(extPins),
    .port_b_inputs(portPins), .periphEvents(periphEvents), .vectorOut(vectorOut),
    .return_from_interrupt_op(retOp));
  core_model u_core_model (.ref_clk(ref_clk), .reset_n(reset_n), .vectorOut(vectorOut),
    .return_from_interrupt_op(retOp), .retReq(retReq));
  // ************************************
  // helpers
  // ************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // registers are changed by single writes only
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
    logic awDone, wDone;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone))
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
      begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge ref_clk);
    check(34'(bresp), 34'(r));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
    @(posedge ref_clk);
    rdQ.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge ref_clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge ref_clk);
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    periphEvents <= 8'h01 << i;
    @(posedge ref_clk);
    periphEvents <= 8'h00;
  endtask
  task automatic ret;
    @(posedge ref_clk);
    retReq <= 1'b1;
    @(posedge ref_clk);
    retReq <= 1'b0;
    idle(3);
  endtask
  // ************************************
  // clock, monitor and sequence
  // ************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (rvalid && rready)
      check({rresp, rdata}, rdQ.size() ? rdQ.pop_front() : 34'h3FFFFFFFF);
    if (vectorOut.take === 1'b1)
      check({vectorOut.high, vectorOut.addr}, vecQ.size() ? vecQ.pop_front() : 17'h1FFFF);
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, retReq} = 6'h00;
    {awaddr, araddr, periphEvents, portPins, extPins} = 31'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    reset_n = 1'b0;
    rng = xs(32'd34689);
    k = int'(rng % 8);
    j = (k + 3) % 8;
    idle(6);
    reset_n <= 1'b1;
    rd(`OFS_ICR, 32'h0);
    rd(`OFS_RCR, 32'h0);
    rd(`OFS_PRI, 32'hFFF);
    rd(`OFS_EDGE, `EDGE_RESET);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(8'h20, 32'hFF, `RESP_SLVERR);
    pulse(k);
    rd(`OFS_FLAG, 32'h1 << (4 + k));
    wr(`OFS_EN, 32'h1 << (4 + k));
    wr(`OFS_PRI, 32'h0);
    pulse(j);
    wr(`OFS_ICR, 32'h80);
    rd(`OFS_STAT, 32'h0);
    vecQ.push_back({1'b1, `VEC_HIGH});
    wr(`OFS_ICR, 32'hC0);
    idle(4);
    rd(`OFS_ICR, 32'h40);
    wr(`OFS_FLAG, 32'h1 << (4 + j));
    ret();
    rd(`OFS_ICR, 32'hC0);
    rd(`OFS_STAT, 32'h0);
    wr(`OFS_FLAG, 32'h0);
    wr(`OFS_RCR, 32'h80);
    wr(`OFS_EN, (32'h1 << (4 + k)) | (32'h1 << (4 + j)));
    wr(`OFS_PRI, 32'h1 << (4 + j));
    vecQ.push_back({1'b0, `VEC_LOW});
    pulse(k);
    idle(4);
    rd(`OFS_ICR, 32'h80);
    vecQ.push_back({1'b1, `VEC_HIGH});
    pulse(j);
    idle(4);
    rd(`OFS_STAT, 32'h3);
    wr(`OFS_FLAG, 32'h1 << (4 + k));
    wr(`OFS_ICR, 32'hC0);
    idle(4);
    rd(`OFS_STAT, 32'h3);
    ret();
    rd(`OFS_STAT, 32'h1);
    wr(`OFS_FLAG, 32'h0);
    ret();
    rd(`OFS_ICR, 32'hC0);
    wr(`OFS_RCR, 32'h0);
    wr(`OFS_EN, 32'h2);
    wr(`OFS_ICR, 32'h80);
    vecQ.push_back({1'b1, `VEC_HIGH});
    @(posedge ref_clk);
    extPins <= 3'h1;
    lat = 0;
    while (vectorOut.take !== 1'b1 && lat < 10)
    begin
      @(posedge ref_clk);
      #1;
      lat++;
    end
    check(34'(lat == 3 || lat == 4), 34'h1);
    wr(`OFS_FLAG, 32'h0);
    ret();
    wr(`OFS_ICR, 32'h0);
    @(posedge ref_clk);
    extPins <= 3'h0;
    idle(4);
    rd(`OFS_FLAG, 32'h0);
    wr(`OFS_EDGE, 32'h6);
    @(posedge ref_clk);
    extPins <= 3'h1;
    idle(4);
    rd(`OFS_FLAG, 32'h0);
    @(posedge ref_clk);
    extPins <= 3'h0;
    idle(4);
    rd(`OFS_FLAG, 32'h2);
    wr(`OFS_FLAG, 32'h0);
    @(posedge ref_clk);
    portPins <= 4'hA;
    idle(4);
    wr(`OFS_FLAG, 32'h0);
    rd(`OFS_FLAG, 32'h1);
    rd(`OFS_PORT, 32'hA);
    wr(`OFS_FLAG, 32'h0);
    rd(`OFS_FLAG, 32'h0);
    idle(4);
    check(34'(vecQ.size() + rdQ.size()), 34'h0);
    summarize();
  end
endmodule

// >>> hdl/irq_ctrl_map.svh
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
`define OFS_ICR 8'h00
`define OFS_RCR 8'h04
`define OFS_FLAG 8'h08
`define OFS_EN 8'h0C
`define OFS_PRI 8'h10
`define OFS_EDGE 8'h14
`define OFS_PORT 8'h18
`define OFS_STAT 8'h1C
`define BIT_HIGH_EN 7
`define BIT_LOW_EN 6
`define BIT_MODE 7
`define VEC_HIGH 16'h0008
`define VEC_LOW 16'h0018
`define SRC_PORT 0
`define SRC_EXT0 1
`define NUM_EXT 3
`define NUM_PORT 4
`define FIRST_PERIPH 4
`define EDGE_RESET 3'h7
`define PIN_LATENCY_MAX 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  typedef enum logic [1:0] {SVC_IDLE, SVC_LOW, SVC_HIGH, SVC_HIGH_OVER_LOW} svc_state_t;
  typedef struct packed {
    logic take;
    logic high;
    logic [15:0] addr;
  } vector_t;
endpackage

// >>> hdl/two_level_priority_interrupt_unit.sv
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`include "irq_ctrl_map.svh"
module two_level_priority_interrupt_unit #(
  parameter int NUM_PERIPH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // event sources
  input wire logic [`NUM_EXT-1:0] extPins,
  input wire logic [`NUM_PORT-1:0] port_b_inputs,
  input wire logic [NUM_PERIPH-1:0] periphEvents,
  // core side
  output irq_ctrl_pkg::vector_t vectorOut,
  input wire logic return_from_interrupt_op
);
  import irq_ctrl_pkg::*;
  localparam int NS = `FIRST_PERIPH + NUM_PERIPH;

  // ****************************************
  // pin synchronisers and event detection
  // ****************************************
  logic [`NUM_EXT-1:0] extS1_q, extS2_q, extPrev_q, extEvent;
  logic [`NUM_PORT-1:0] portS1_q, portS2_q, portLatch_q;
  logic [`NUM_EXT-1:0] external_edge_select_q;
  logic portRead;
  logic mismatch;

  genvar g;
  generate
    for (g = 0; g < `NUM_EXT; g++)
    begin : gExt
      always_ff @(posedge ref_clk)
      begin
        if (!reset_n)
        begin
          extS1_q[g] <= 1'b0;
          extS2_q[g] <= 1'b0;
          extPrev_q[g] <= 1'b0;
        end
        else
        begin
          extS1_q[g] <= extPins[g];
          extS2_q[g] <= extS1_q[g];
          extPrev_q[g] <= extS2_q[g];
        end
      end
      // rising when select is one, falling when zero
      assign extEvent[g] = external_edge_select_q[g] ? (extS2_q[g] & ~extPrev_q[g])
                                                     : (~extS2_q[g] & extPrev_q[g]);
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      portS1_q <= '0;
      portS2_q <= '0;
    end
    else
    begin
      portS1_q <= port_b_inputs;
      portS2_q <= portS1_q;
    end
  end

  // a port read resyncs the latch, ending the mismatch
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      portLatch_q <= '0;
    else if (portRead)
      portLatch_q <= portS2_q;
  end
  assign mismatch = (portS2_q != portLatch_q);

  logic [NS-1:0] srcEvent;
  assign srcEvent = {periphEvents, extEvent, mismatch};

  // ****************************************
  // register bus
  // ****************************************
  logic awHave_q, wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [31:0] wMask;

  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready = !wHave_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      else if (doWrite)
        awHave_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      else if (doWrite)
        wHave_q <= 1'b0;
    end
  end

  logic mapped;
  always_comb
  begin
    case (awAddr_q)
      `OFS_ICR, `OFS_RCR, `OFS_FLAG, `OFS_EN, `OFS_PRI, `OFS_EDGE, `OFS_PORT, `OFS_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [31:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  logic wrIcr, wrRcr, wrFlag, wrEn, wrPri, wrEdge;
  assign wrIcr = doWrite && awAddr_q == `OFS_ICR;
  assign wrRcr = doWrite && awAddr_q == `OFS_RCR;
  assign wrFlag = doWrite && awAddr_q == `OFS_FLAG;
  assign wrEn = doWrite && awAddr_q == `OFS_EN;
  assign wrPri = doWrite && awAddr_q == `OFS_PRI;
  assign wrEdge = doWrite && awAddr_q == `OFS_EDGE;

  // ****************************************
  // per-source bits and global gates
  // ****************************************
  logic [NS-1:0] flag_q, enable_q, priority_q;
  logic high_level_global_enable_q, low_level_global_enable_q, priority_mode_enable_q;
  logic [31:0] wFlag;
  assign wFlag = merge(32'(flag_q), wData_q, wMask);

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      flag_q <= '0;
    else
      flag_q <= srcEvent | (wrFlag ? wFlag[NS-1:0] : flag_q);
  end

  logic [31:0] wEn, wPri;
  assign wEn = merge(32'(enable_q), wData_q, wMask);
  assign wPri = merge(32'(priority_q), wData_q, wMask);
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      enable_q <= '0;
      priority_q <= '1;
      external_edge_select_q <= `EDGE_RESET;
      priority_mode_enable_q <= 1'b0;
    end
    else
    begin
      if (wrEn)
        enable_q <= wEn[NS-1:0];
      if (wrPri)
        priority_q <= wPri[NS-1:0];
      if (wrEdge && wStrb_q[0])
        external_edge_select_q <= wData_q[`NUM_EXT-1:0];
      if (wrRcr && wStrb_q[0])
        priority_mode_enable_q <= wData_q[`BIT_MODE];
    end
  end

  // ****************************************
  // arbitration and service tracking
  // ****************************************
  svc_state_t svc_q;
  logic [NS-1:0] live, periphMask;
  logic highReq, lowReq, takeHigh, takeLow, retHigh, retLow;

  assign periphMask = {{NUM_PERIPH{1'b1}}, {`FIRST_PERIPH{1'b0}}};
  assign live = flag_q & enable_q;

  always_comb
  begin
    if (priority_mode_enable_q)
    begin
      highReq = |(live & priority_q) && high_level_global_enable_q;
      lowReq = |(live & ~priority_q) && high_level_global_enable_q && low_level_global_enable_q;
    end
    else
    begin
      // priority bits ignored; bit6 gates peripherals, bit7 all
      highReq = high_level_global_enable_q &&
                |(live & (~periphMask | {NS{low_level_global_enable_q}}));
      lowReq = 1'b0;
    end
  end

  assign takeHigh = highReq && svc_q != SVC_HIGH && svc_q != SVC_HIGH_OVER_LOW;
  assign takeLow = !takeHigh && lowReq && svc_q == SVC_IDLE;
  assign retHigh = return_from_interrupt_op && (svc_q == SVC_HIGH || svc_q == SVC_HIGH_OVER_LOW);
  assign retLow = return_from_interrupt_op && svc_q == SVC_LOW;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      svc_q <= SVC_IDLE;
    else if (takeHigh)
      svc_q <= (svc_q == SVC_LOW) ? SVC_HIGH_OVER_LOW : SVC_HIGH;
    else if (takeLow)
      svc_q <= SVC_LOW;
    else if (return_from_interrupt_op)
    begin
      case (svc_q)
        SVC_HIGH_OVER_LOW: svc_q <= SVC_LOW;
        SVC_HIGH, SVC_LOW: svc_q <= SVC_IDLE;
        default: svc_q <= SVC_IDLE;
      endcase
    end
  end

  // hardware clear/restore takes precedence over a software write
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      high_level_global_enable_q <= 1'b0;
      low_level_global_enable_q <= 1'b0;
    end
    else
    begin
      if (takeHigh)
        high_level_global_enable_q <= 1'b0;
      else if (retHigh)
        high_level_global_enable_q <= 1'b1;
      else if (wrIcr && wStrb_q[0])
        high_level_global_enable_q <= wData_q[`BIT_HIGH_EN];
      if (takeLow)
        low_level_global_enable_q <= 1'b0;
      else if (retLow)
        low_level_global_enable_q <= 1'b1;
      else if (wrIcr && wStrb_q[0])
        low_level_global_enable_q <= wData_q[`BIT_LOW_EN];
    end
  end

  // one-cycle strobe: core pushes return address and jumps
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      vectorOut <= '0;
    else
    begin
      vectorOut.take <= takeHigh || takeLow;
      vectorOut.high <= takeHigh;
      vectorOut.addr <= takeLow ? `VEC_LOW : `VEC_HIGH;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [31:0] rdMux;
  logic rdOk;
  always_comb
  begin
    rdMux = '0;
    rdOk = 1'b1;
    case (s_axi_araddr)
      `OFS_ICR: rdMux = 32'({high_level_global_enable_q, low_level_global_enable_q, 6'h00});
      `OFS_RCR: rdMux = 32'({priority_mode_enable_q, 7'h00});
      `OFS_FLAG: rdMux = 32'(flag_q);
      `OFS_EN: rdMux = 32'(enable_q);
      `OFS_PRI: rdMux = 32'(priority_q);
      `OFS_EDGE: rdMux = 32'(external_edge_select_q);
      `OFS_PORT: rdMux = 32'(portS2_q);
      `OFS_STAT: rdMux = 32'(svc_q);
      default: rdOk = 1'b0;
    endcase
  end
  assign portRead = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_PORT;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // checks
  // ****************************************
  AST_VEC_ADDR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    vectorOut.take |-> vectorOut.addr == (vectorOut.high ? `VEC_HIGH : `VEC_LOW))
    else $error("vector address does not match level");
  AST_COMPAT_HIGH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !priority_mode_enable_q && (takeHigh || takeLow) |=> vectorOut.addr == `VEC_HIGH)
    else $error("compatibility mode used low vector");
  AST_PREEMPT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    svc_q == SVC_LOW && highReq |=> svc_q == SVC_HIGH_OVER_LOW && vectorOut.take)
    else $error("high request did not pre-empt low service");
  AST_HOLD_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (svc_q == SVC_HIGH || svc_q == SVC_HIGH_OVER_LOW) |=> !(vectorOut.take && !vectorOut.high))
    else $error("low request taken during high service");
  AST_CLEAR_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    takeHigh |=> !high_level_global_enable_q)
    else $error("high gate not cleared on accept");
  AST_CLEAR_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    takeLow |=> !low_level_global_enable_q && high_level_global_enable_q)
    else $error("wrong gate cleared on low accept");
  AST_RESTORE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    retHigh && !takeHigh |=> high_level_global_enable_q)
    else $error("return did not restore high gate");
  AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    srcEvent[`SRC_EXT0] |=> flag_q[`SRC_EXT0])
    else $error("event did not set its flag");
  AST_DISABLED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (live == '0) |=> !vectorOut.take)
    else $error("vector with no enabled flag");
  AST_PIN_LAT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(extS2_q[0]) && external_edge_select_q[0] && enable_q[`SRC_EXT0]
      && (priority_q[`SRC_EXT0] || !priority_mode_enable_q)
      && high_level_global_enable_q && svc_q == SVC_IDLE && !return_from_interrupt_op && !wrIcr
      && !wrEn && !wrEdge && !wrPri && !wrRcr |-> ##2 vectorOut.take)
    else $error("pin event latency exceeded");
endmodule
